// ==== core/texture_block_decoder_pkg.sv ====
// Shared constants for the 4x4 compressed texture block decoder.
// Assumes a 32-bit AHB-Lite register bus with one word per register.
package texture_block_decoder_pkg;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] COORD_OFS = 8'h04;
    localparam logic [7:0] COLOUR_HI_OFS = 8'h08;
    localparam logic [7:0] COLOUR_LO_OFS = 8'h0c;
    localparam logic [7:0] ALPHA_HI_OFS = 8'h10;
    localparam logic [7:0] ALPHA_LO_OFS = 8'h14;
    localparam logic [7:0] PAIR_BASE_OFS = 8'h18;
    localparam logic [7:0] STATUS_OFS = 8'h1c;
    localparam logic [7:0] RESULT_OFS = 8'h20;

    // Control fields: start strobe, colour mode, sRGB tag.
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_SRGB_BIT = 3;
    localparam logic [1:0] CTRL_MODE_RESET = 2'h0;

    // Colour mode codes.
    localparam logic [1:0] MODE_SKEWED = 2'h0;
    localparam logic [1:0] MODE_SYMMETRIC = 2'h1;
    localparam logic [1:0] MODE_PLANAR = 2'h2;

    // Pair base register fields.
    localparam int PB_BASE1_MSB = 23;
    localparam int PB_BASE2_MSB = 11;
    localparam int PB_DIST_HI_LSB = 25;
    localparam int PB_DIST_LO_BIT = 24;

    // Colour pixel index: high bit at 16 + texel, low bit at texel.
    localparam int PIX_IDX_HI_BASE = 16;

    // Planar field positions in the colour word.
    localparam int PL_OR_MSB = 62;
    localparam int PL_OG1_BIT = 56;
    localparam int PL_OG2_MSB = 54;
    localparam int PL_OB1_BIT = 48;
    localparam int PL_OB2_MSB = 44;
    localparam int PL_OB3_MSB = 41;
    localparam int PL_HR1_MSB = 38;
    localparam int PL_HR2_BIT = 32;
    localparam int PL_HG_MSB = 31;
    localparam int PL_HB_MSB = 24;
    localparam int PL_VR_MSB = 18;
    localparam int PL_VG_MSB = 12;
    localparam int PL_VB_MSB = 5;

    // Alpha word fields.
    localparam int AL_BASE_MSB = 63;
    localparam int AL_MULT_MSB = 55;
    localparam int AL_TAB_MSB = 51;
    localparam int AL_IDX_MSB = 47;

    // Distance table for both pair modes.
    localparam logic [7:0] DIST_TAB [8] = '{8'd3, 8'd6, 8'd11, 8'd16, 8'd23, 8'd32, 8'd41, 8'd64};

    // Alpha modifier tables, entry 0 leftmost.
    localparam logic signed [7:0] ALPHA_MOD_TAB [16][8] = '{
        '{-8'sd3, -8'sd6, -8'sd9, -8'sd15, 8'sd2, 8'sd5, 8'sd8, 8'sd14},
        '{-8'sd3, -8'sd7, -8'sd10, -8'sd13, 8'sd2, 8'sd6, 8'sd9, 8'sd12},
        '{-8'sd2, -8'sd5, -8'sd8, -8'sd13, 8'sd1, 8'sd4, 8'sd7, 8'sd12},
        '{-8'sd2, -8'sd4, -8'sd6, -8'sd13, 8'sd1, 8'sd3, 8'sd5, 8'sd12},
        '{-8'sd3, -8'sd6, -8'sd8, -8'sd12, 8'sd2, 8'sd5, 8'sd7, 8'sd11},
        '{-8'sd3, -8'sd7, -8'sd9, -8'sd11, 8'sd2, 8'sd6, 8'sd8, 8'sd10},
        '{-8'sd4, -8'sd7, -8'sd8, -8'sd11, 8'sd3, 8'sd6, 8'sd7, 8'sd10},
        '{-8'sd3, -8'sd5, -8'sd8, -8'sd11, 8'sd2, 8'sd4, 8'sd7, 8'sd10},
        '{-8'sd2, -8'sd6, -8'sd8, -8'sd10, 8'sd1, 8'sd5, 8'sd7, 8'sd9},
        '{-8'sd2, -8'sd5, -8'sd8, -8'sd10, 8'sd1, 8'sd4, 8'sd7, 8'sd9},
        '{-8'sd2, -8'sd4, -8'sd8, -8'sd10, 8'sd1, 8'sd3, 8'sd7, 8'sd9},
        '{-8'sd2, -8'sd5, -8'sd7, -8'sd10, 8'sd1, 8'sd4, 8'sd6, 8'sd9},
        '{-8'sd3, -8'sd4, -8'sd7, -8'sd10, 8'sd2, 8'sd3, 8'sd6, 8'sd9},
        '{-8'sd1, -8'sd2, -8'sd3, -8'sd10, 8'sd0, 8'sd1, 8'sd2, 8'sd9},
        '{-8'sd4, -8'sd6, -8'sd8, -8'sd9, 8'sd3, 8'sd5, 8'sd7, 8'sd8},
        '{-8'sd3, -8'sd5, -8'sd7, -8'sd9, 8'sd2, 8'sd4, 8'sd6, 8'sd8}
    };

    // Saturates a signed intermediate to an 8-bit channel.
    function automatic logic [7:0] clamp_u8(input logic signed [12:0] v);
        logic [7:0] r;
        r = v[7:0];
        if (v < 13'sd0) begin
            r = 8'h00;
        end else if (v > 13'sd255) begin
            r = 8'hff;
        end
        return r;
    endfunction

endpackage

// ==== core/alpha_if.sv ====
// Carries one alpha decode request and its answer between modules.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ns
`default_nettype none
interface alpha_if;
    logic [63:0] alpha_word; // Alpha half of the block.
    logic [3:0] texel_num; // Texel number, x * 4 + y.
    logic [7:0] alpha; // Decoded alpha.
    modport requester (output alpha_word, output texel_num, input alpha);
    modport decoder (input alpha_word, input texel_num, output alpha);
endinterface
`default_nettype wire

// ==== core/alpha_texel_decoder.sv ====
// Combinational alpha decoder for one texel of a 64-bit alpha word.
// Assumes the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module alpha_texel_decoder
    import texture_block_decoder_pkg::*;
(
    alpha_if.decoder port_a // Request and answer.
);
    logic [7:0] base; // Alpha base value.
    logic [3:0] mult; // Multiplier.
    logic [3:0] tab; // Modifier table number.
    logic [47:0] idx_shifted; // Index field moved so the texel sits on top.
    logic [5:0] shift_amt; // Three bits per texel.
    logic [2:0] pix_idx; // Texel's 3-bit pixel index.
    logic signed [12:0] modifier; // Selected table entry, sign extended.
    logic signed [12:0] sum; // Base plus scaled modifier.

    // Field extraction, table lookup and saturation.
    always_comb begin
        base = port_a.alpha_word[AL_BASE_MSB -: 8]; // [R15]
        mult = port_a.alpha_word[AL_MULT_MSB -: 4]; // [R15]
        tab = port_a.alpha_word[AL_TAB_MSB -: 4]; // [R15]
        // Texel a sits on top, each later texel three bits lower.
        shift_amt = 6'({2'h0, port_a.texel_num} * 6'd3);
        idx_shifted = port_a.alpha_word[AL_IDX_MSB:0] << shift_amt; // [R16]
        pix_idx = idx_shifted[47:45]; // [R16]
        modifier = 13'(ALPHA_MOD_TAB[tab][pix_idx]); // [R18]
        // A zero multiplier simply zeroes the product, leaving the base. [R19]
        sum = $signed({5'h00, base}) + modifier * $signed({9'h000, mult}); // [R17]
        port_a.alpha = clamp_u8(sum); // [R17]
    end
endmodule
`default_nettype wire

// ==== core/texture_block_decoder.sv ====
// Texture block decoder: pair-colour modes, planar mode and alpha word.
// Assumes an AHB-Lite master on hclk; software loads a block, then starts.
//
// Operation
// R01: Distance index selects hardwired distance table value.
// R02: Skewed pair paints: base one, two plus/same/minus.
// R03: Skewed pair paint channels saturate to 0..255.
// R04: Symmetric index low bit compares packed base colours.
// R05: Symmetric paints: base one and two, plus/minus.
// R06: Symmetric pair paint channels saturate to 0..255.
// R07: Texel picks paint by 2-bit pixel index.
// R08: Planar takes origin, horizontal, vertical 676 colours.
// R09: Split planar channels are concatenated piecewise.
// R10: Six-bit planar channels widen by top-bit copy.
// R11: Planar channel is rounded plane, shifted, saturated.
// R12: Planar x follows u, y follows v.
// R13: sRGB variant decodes to identical 8-bit values.
// R14: Colour-plus-alpha block is alpha word plus colour word.
// R15: Alpha base, multiplier, table fields at fixed bits.
// R16: Sixteen 3-bit alpha indices, texel a topmost.
// R17: Alpha equals base plus modifier times multiplier, saturated.
// R18: Sixteen fixed alpha tables, eight signed entries.
// R19: Zero multiplier yields the base value alone.
// R20: Skewed index is high bits shifted, OR low bit.
// R21: Pair base channels widen 4 to 8 bits.
// R22: Results registered one cycle after accepted request.
// R23: Requester holds inputs and waits for valid.
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module texture_block_decoder
    import texture_block_decoder_pkg::*;
(
    input wire logic hclk, // Bus and core clock.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic hsel, // Slave select.
    input wire logic [31:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write when high.
    input wire logic [2:0] hsize, // Transfer size.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Bus ready.
    output logic [31:0] hrdata, // Read data, registered.
    output logic hreadyout, // Always ready.
    output logic hresp, // Always OKAY.
    output logic [7:0] texel_red, // Decoded red.
    output logic [7:0] texel_green, // Decoded green.
    output logic [7:0] texel_blue, // Decoded blue.
    output logic [7:0] texel_alpha, // Decoded alpha.
    output logic texel_valid // Result valid.
);
    // Bus pipeline state.
    logic dp_write; // Word write in its data phase.
    logic [7:0] dp_addr; // Its address.
    logic next_dp_write;
    logic [7:0] next_dp_addr;
    logic [31:0] next_hrdata; // Read data for the data phase.
    logic ap_valid; // Address phase taken.

    // Software visible configuration, then next values.
    logic [1:0] mode; // Colour mode code.
    logic srgb; // sRGB tag, stored only.
    logic [1:0] coord_x; // Texel column, u direction.
    logic [1:0] coord_y; // Texel row, v direction.
    logic [63:0] colour_word; // Colour half of the block.
    logic [63:0] alpha_word; // Alpha half of the block.
    logic [26:0] pair_base; // Pair-mode base colours and distance bits.
    logic req; // Decode request pending for one cycle.
    logic [1:0] next_mode;
    logic next_srgb;
    logic [1:0] next_coord_x;
    logic [1:0] next_coord_y;
    logic [63:0] next_colour_word;
    logic [63:0] next_alpha_word;
    logic [26:0] next_pair_base;
    logic next_req;

    // Next result values.
    logic [7:0] next_red;
    logic [7:0] next_green;
    logic [7:0] next_blue;
    logic [7:0] next_alpha;
    logic next_valid;

    // Datapath signals.
    logic [3:0] texel_num; // Texel number, column-major as a..p.
    logic [1:0] pix_idx; // Colour pixel index of this texel.
    logic [1:0] dist_hi_bits; // High distance field.
    logic dist_lo_bit; // Low distance bit.
    logic [7:0] base1 [3]; // Base colour one, widened.
    logic [7:0] base2 [3]; // Base colour two, widened.
    logic [7:0] origin [3]; // Planar origin per channel.
    logic [7:0] horiz [3]; // Planar horizontal per channel.
    logic [7:0] vert [3]; // Planar vertical per channel.
    logic [7:0] chan [3]; // Decoded colour per channel.
    logic base1_ge_base2; // Packed base one at least base two.
    logic [2:0] dist_idx; // Distance table index.
    logic [7:0] distance; // Selected distance.
    logic [5:0] origin_red; // Planar origin red.
    logic [6:0] origin_green; // Planar origin green.
    logic [5:0] origin_blue; // Planar origin blue.
    logic origin_blue_piece_one; // Top bit of origin blue.
    logic [5:0] horizontal_red;
    logic [6:0] horizontal_green;
    logic [5:0] horizontal_blue;
    logic [5:0] vertical_red;
    logic [6:0] vertical_green;
    logic [5:0] vertical_blue;
    logic [7:0] alpha_dec; // Alpha from the alpha decoder.

    alpha_if alpha_link (); // Link to the alpha decoder.

    // The alpha word always goes through the same path. [R14]
    assign alpha_link.alpha_word = alpha_word;
    assign alpha_link.texel_num = texel_num;
    assign alpha_dec = alpha_link.alpha;

    alpha_texel_decoder u_alpha (
        .port_a(alpha_link.decoder)
    );

    // Zero wait states and no error responses keep the master simple.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ap_valid = hsel & hready & htrans[1];

    // Column-major numbering: texel a is (0,0), b is (0,1), e is (1,0). [R12]
    assign texel_num = {coord_x, coord_y};
    // Pixel index bits sit at 16 + n and n of the colour word. [R07]
    assign pix_idx = {colour_word[PIX_IDX_HI_BASE + 32'(texel_num)], colour_word[texel_num]};
    assign dist_hi_bits = pair_base[PB_DIST_HI_LSB +: 2];
    assign dist_lo_bit = pair_base[PB_DIST_LO_BIT];

    // Packed R<<16 + G<<8 + B compares as a plain 24-bit concatenation. [R04]
    assign base1_ge_base2 = {base1[0], base1[1], base1[2]} >= {base2[0], base2[1], base2[2]};

    // Distance index per mode; symmetric mode reads only the low bit of the high field.
    always_comb begin
        if (mode == MODE_SYMMETRIC) begin
            dist_idx = {dist_hi_bits[0], dist_lo_bit, base1_ge_base2}; // [R04]
        end else begin
            dist_idx = {dist_hi_bits, dist_lo_bit}; // [R20]
        end
    end
    assign distance = DIST_TAB[dist_idx]; // [R01]

    // Planar fields, split channels joined top piece first. [R08] [R09]
    assign origin_red = colour_word[PL_OR_MSB -: 6];
    assign origin_green = {colour_word[PL_OG1_BIT], colour_word[PL_OG2_MSB -: 6]};
    assign origin_blue_piece_one = colour_word[PL_OB1_BIT];
    assign origin_blue = {origin_blue_piece_one, colour_word[PL_OB2_MSB -: 2], colour_word[PL_OB3_MSB -: 3]};
    assign horizontal_red = {colour_word[PL_HR1_MSB -: 5], colour_word[PL_HR2_BIT]};
    assign horizontal_green = colour_word[PL_HG_MSB -: 7];
    assign horizontal_blue = colour_word[PL_HB_MSB -: 6];
    assign vertical_red = colour_word[PL_VR_MSB -: 6];
    assign vertical_green = colour_word[PL_VG_MSB -: 7];
    assign vertical_blue = colour_word[PL_VB_MSB -: 6];

    // Widening: six-bit channels copy two top bits, green copies one. [R10]
    assign origin[0] = {origin_red, origin_red[5:4]};
    assign origin[1] = {origin_green, origin_green[6]};
    assign origin[2] = {origin_blue, origin_blue[5:4]};
    assign horiz[0] = {horizontal_red, horizontal_red[5:4]};
    assign horiz[1] = {horizontal_green, horizontal_green[6]};
    assign horiz[2] = {horizontal_blue, horizontal_blue[5:4]};
    assign vert[0] = {vertical_red, vertical_red[5:4]};
    assign vert[1] = {vertical_green, vertical_green[6]};
    assign vert[2] = {vertical_blue, vertical_blue[5:4]};

    // One decode lane per colour channel; 0 red, 1 green, 2 blue.
    for (genvar c = 0; c < 3; c++) begin : g_chan
        logic [3:0] nib1; // Base one nibble.
        logic [3:0] nib2; // Base two nibble.
        logic signed [12:0] b1s;
        logic signed [12:0] b2s;
        logic signed [12:0] ds;
        logic signed [12:0] os;
        logic signed [12:0] hs;
        logic signed [12:0] vs;
        logic signed [12:0] xs;
        logic signed [12:0] ys;
        logic signed [12:0] acc; // Planar sum before the shift.
        logic [7:0] paint [4]; // Paint colours of this channel.
        logic [7:0] planar; // Planar result.

        assign nib1 = pair_base[PB_BASE1_MSB - 4 * c -: 4];
        assign nib2 = pair_base[PB_BASE2_MSB - 4 * c -: 4];
        assign base1[c] = {nib1, nib1}; // [R21]
        assign base2[c] = {nib2, nib2}; // [R21]
        assign b1s = $signed({5'h00, base1[c]});
        assign b2s = $signed({5'h00, base2[c]});
        assign ds = $signed({5'h00, distance});
        assign os = $signed({5'h00, origin[c]});
        assign hs = $signed({5'h00, horiz[c]});
        assign vs = $signed({5'h00, vert[c]});
        assign xs = $signed({11'h000, coord_x}); // [R12]
        assign ys = $signed({11'h000, coord_y}); // [R12]

        // Rounding bias of 2 makes ties go upward before the shift. [R11]
        assign acc = xs * (hs - os) + ys * (vs - os) + (os <<< 2) + 13'sd2;
        assign planar = clamp_u8(acc >>> 2); // [R11]

        // Paint colours per pair mode, each sum saturated.
        always_comb begin
            if (mode == MODE_SYMMETRIC) begin
                paint[0] = clamp_u8(b1s + ds); // [R05] [R06]
                paint[1] = clamp_u8(b1s - ds); // [R05] [R06]
                paint[2] = clamp_u8(b2s + ds); // [R05] [R06]
                paint[3] = clamp_u8(b2s - ds); // [R05] [R06]
            end else begin
                paint[0] = base1[c]; // [R02]
                paint[1] = clamp_u8(b2s + ds); // [R02] [R03]
                paint[2] = base2[c]; // [R02]
                paint[3] = clamp_u8(b2s - ds); // [R02] [R03]
            end
        end

        // The sRGB tag plays no part here; conversion lives downstream. [R13]
        assign chan[c] = (mode == MODE_PLANAR) ? planar : paint[pix_idx]; // [R07]
    end

    // Next values for the bus pipeline and configuration registers.
    always_comb begin
        next_dp_write = ap_valid & hwrite & (hsize == 3'h2);
        next_dp_addr = haddr[7:0];
        next_hrdata = 32'h0000_0000;
        next_mode = mode;
        next_srgb = srgb;
        next_coord_x = coord_x;
        next_coord_y = coord_y;
        next_colour_word = colour_word;
        next_alpha_word = alpha_word;
        next_pair_base = pair_base;
        next_req = 1'b0;
        // Reads are answered from the address phase so hrdata is a flop.
        if (ap_valid && !hwrite) begin
            case (haddr[7:0])
                CTRL_OFS: next_hrdata = 32'({srgb, mode, 1'b0});
                COORD_OFS: next_hrdata = 32'({coord_y, coord_x});
                COLOUR_HI_OFS: next_hrdata = colour_word[63:32];
                COLOUR_LO_OFS: next_hrdata = colour_word[31:0];
                ALPHA_HI_OFS: next_hrdata = alpha_word[63:32];
                ALPHA_LO_OFS: next_hrdata = alpha_word[31:0];
                PAIR_BASE_OFS: next_hrdata = 32'(pair_base);
                STATUS_OFS: next_hrdata = 32'({req, texel_valid});
                RESULT_OFS: next_hrdata = {texel_red, texel_green, texel_blue, texel_alpha};
                default: next_hrdata = 32'h0000_0000; // Unmapped reads return zero.
            endcase
        end
        // Writes land at the end of their data phase.
        if (dp_write) begin
            case (dp_addr)
                CTRL_OFS: begin
                    next_mode = hwdata[CTRL_MODE_LSB +: 2];
                    next_srgb = hwdata[CTRL_SRGB_BIT];
                    next_req = hwdata[CTRL_START_BIT];
                end
                COORD_OFS: begin
                    next_coord_x = hwdata[1:0];
                    next_coord_y = hwdata[3:2];
                end
                COLOUR_HI_OFS: begin
                    next_colour_word[63:32] = hwdata;
                end
                COLOUR_LO_OFS: begin
                    next_colour_word[31:0] = hwdata;
                end
                ALPHA_HI_OFS: begin
                    next_alpha_word[63:32] = hwdata;
                end
                ALPHA_LO_OFS: begin
                    next_alpha_word[31:0] = hwdata;
                end
                PAIR_BASE_OFS: begin
                    next_pair_base = hwdata[26:0];
                end
                default: next_req = 1'b0; // Writes elsewhere are dropped.
            endcase
        end
    end

    // Registers for the bus pipeline and configuration.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            mode <= CTRL_MODE_RESET;
            srgb <= 1'b0;
            coord_x <= 2'h0;
            coord_y <= 2'h0;
            colour_word <= 64'h0;
            alpha_word <= 64'h0;
            pair_base <= 27'h0;
            req <= 1'b0;
        end else begin
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            hrdata <= next_hrdata;
            mode <= next_mode;
            srgb <= next_srgb;
            coord_x <= next_coord_x;
            coord_y <= next_coord_y;
            colour_word <= next_colour_word;
            alpha_word <= next_alpha_word;
            pair_base <= next_pair_base;
            req <= next_req;
        end
    end

    // Result capture: a request is decoded and latched one cycle later.
    // A new start clears valid, but a latch in the same cycle wins. [R22]
    always_comb begin
        next_red = texel_red;
        next_green = texel_green;
        next_blue = texel_blue;
        next_alpha = texel_alpha;
        next_valid = texel_valid;
        if (req) begin
            next_red = chan[0];
            next_green = chan[1];
            next_blue = chan[2];
            next_alpha = alpha_dec;
            next_valid = 1'b1; // [R22]
        end else if (dp_write && dp_addr == CTRL_OFS && hwdata[CTRL_START_BIT]) begin
            next_valid = 1'b0; // Inputs may change now; old result is stale. [R23]
        end
    end

    // Result registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            texel_red <= 8'h00;
            texel_green <= 8'h00;
            texel_blue <= 8'h00;
            texel_alpha <= 8'h00;
            texel_valid <= 1'b0;
        end else begin
            texel_red <= next_red;
            texel_green <= next_green;
            texel_blue <= next_blue;
            texel_alpha <= next_alpha;
            texel_valid <= next_valid;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/texture_block_decoder_chk.sv ====
// Assertions on the decoder's bus and result ports.
// Assumes hready is fed back from hreadyout.
`timescale 1ns/1ns
`default_nettype none
module texture_block_decoder_chk
    import texture_block_decoder_pkg::*;
(
    input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, texel_valid, // Bits.
    input wire logic [31:0] haddr, hwdata, hrdata, // Words.
    input wire logic [1:0] htrans, // Type.
    input wire logic [2:0] hsize, // Size.
    input wire logic [7:0] texel_red, texel_green, texel_blue, texel_alpha // Result.
);
    logic wv, rd, rq; // Write or read data phase, start pending.
    logic [7:0] pa; // Data-phase address.
    logic [31:0] ah; // Last alpha high word.
    wire logic [31:0] tx = {texel_red, texel_green, texel_blue, texel_alpha}; // Packed result.
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Zero wait states: each data phase follows its address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) {wv, rd, rq, pa, ah} <= '0;
        else begin
            wv <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
            rd <= hsel && hready && htrans[1] && !hwrite;
            rq <= wv && pa == CTRL_OFS && hwdata[0];
            pa <= haddr[7:0];
            ah <= wv && pa == ALPHA_HI_OFS ? hwdata : ah;
        end
    end
    sequence s_go; wv && pa == CTRL_OFS && hwdata[0] && !rq; endsequence
    sequence s_done; !texel_valid ##1 texel_valid; endsequence
    AST_START: assert property (s_go |=> s_done) else $error("late result");
    AST_HOLD: assert property (texel_valid && !rq |=> $stable(tx)) else $error("moved");
    AST_BASE: assert property ($rose(texel_valid) && ah[23:20] == 4'h0 |-> texel_alpha == ah[31:24]) else $error("alpha");
    AST_OKAY: assert property (hreadyout && !hresp) else $error("bus response");
    AST_RESULT: assert property (rd && pa == RESULT_OFS && $stable(tx) |-> hrdata == tx) else $error("result");
    AST_UNMAP: assert property (rd && pa > RESULT_OFS |-> hrdata == 32'h0) else $error("unmapped read");
    AST_IDLE: assert property (!rd |-> hrdata == 32'h0) else $error("stale read data");
    AST_RESET: assert property ($rose(hresetn) |-> !texel_valid) else $error("valid after reset");
endmodule
bind texture_block_decoder texture_block_decoder_chk i_chk (.*);
`default_nettype wire

// ==== testbench/ahb_host.sv ====
// AHB-Lite master standing in for the texture sampling logic.
// Assumes one zero-or-more wait slave; single word transfers.
`timescale 1ns/1ns
`default_nettype none
module ahb_host (
    input wire logic hclk, hready, // Clock and ready.
    input wire logic [31:0] hrdata, // Read data.
    output logic hsel = 0, hwrite = 0, tmo = 0, // Select, direction, wait overrun.
    output logic [1:0] htrans = '0, // Type.
    output logic [2:0] hsize = '0, // Size.
    output logic [31:0] haddr = '0, hwdata = '0 // Address and write data.
);
    // Each phase is held until hready is seen high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, w, 3'h2, 24'h0, a};
        k = 0;
        do begin @(posedge hclk); k++; end while (!hready && k < 50);
        tmo <= tmo || !hready;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); k++; end while (!hready && k < 100);
        q = hrdata;
        tmo <= tmo || !hready;
    endtask
endmodule
`default_nettype wire

// ==== testbench/texture_block_decoder_test.sv ====
// Loads random blocks and compares one random texel of each with a bench model.
// Assumes the host model is the decoder's only master.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; $display("wrong value %s %h %h", nm, e, s); end end
module test_texture_block_decoder;
    import texture_block_decoder_pkg::*;
    logic hclk = 0, hresetn = 0; // Clock and reset.
    wire logic hsel, hwrite, hready, hresp, tmo, tv; // Bus bits and result valid.
    wire logic [1:0] htrans;
    wire logic [2:0] hsize;
    wire logic [31:0] haddr, hwdata, hrdata;
    wire logic [7:0] tr, tg, tb, ta; // Texel result.
    int n_fail = 0, n_checks = 0;
    initial forever #4 hclk = ~hclk;
    ahb_host i_host (.hclk, .hready, .hrdata, .hsel, .hwrite, .tmo, .htrans, .hsize, .haddr, .hwdata);
    texture_block_decoder i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout(hready), .hresp, .texel_red(tr), .texel_green(tg), .texel_blue(tb), .texel_alpha(ta),
        .texel_valid(tv));
    function automatic logic [7:0] sat(int v); return v < 0 ? 8'h00 : v > 255 ? 8'hff : 8'(v); endfunction
    function automatic int ext(int v, int w); return (v << (8 - w)) | (v >> (2 * w - 8)); endfunction
    // Expected red, green, blue and alpha of texel n.
    function automatic logic [31:0] model(logic [63:0] c, logic [63:0] a, logic [31:0] b, logic [1:0] m, int n);
        int b1[3], b2[3], o[3], h[3], v[3], r[3], d, p, s;
        o = '{ext(c[62:57], 6), ext({c[56], c[54:49]}, 7), ext({c[48], c[44:43], c[41:39]}, 6)};
        h = '{ext({c[38:34], c[32]}, 6), ext(c[31:25], 7), ext(c[24:19], 6)};
        v = '{ext(c[18:13], 6), ext(c[12:6], 7), ext(c[5:0], 6)};
        for (int i = 0; i < 3; i++) begin
            b1[i] = b[23 - 4 * i -: 4] * 17;
            b2[i] = b[11 - 4 * i -: 4] * 17;
        end
        s = (b1[0] << 16) + (b1[1] << 8) + b1[2] >= (b2[0] << 16) + (b2[1] << 8) + b2[2];
        d = DIST_TAB[m == MODE_SYMMETRIC ? {b[25:24], s[0]} : b[26:24]];
        p = {c[16 + n], c[n]};
        for (int i = 0; i < 3; i++) begin
            r[i] = m == MODE_PLANAR ? ((n >> 2) * (h[i] - o[i]) + (n & 3) * (v[i] - o[i]) + 4 * o[i] + 2) >>> 2
                : m == MODE_SYMMETRIC ? (p[1] ? b2[i] : b1[i]) + (p[0] ? -d : d)
                : p == 0 ? b1[i] : b2[i] + (p == 2 ? 0 : p == 1 ? d : -d);
        end
        return {sat(r[0]), sat(r[1]), sat(r[2]),
            sat(int'(a[63:56]) + ALPHA_MOD_TAB[a[51:48]][a[47 - 3 * n -: 3]] * int'(a[55:52]))};
    endfunction
    task automatic close_out();
        if (i_host.tmo) n_fail++;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Forty random blocks over every mode code, the first with a zero alpha multiplier.
    initial begin
        logic [63:0] c, a;
        logic [31:0] b, q, w[7];
        logic [1:0] m;
        int n, k;
        void'($urandom(32'h6e686a8c));
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        for (int i = 0; i < 40; i++) begin
            c = {$urandom, $urandom};
            a = {$urandom, $urandom};
            a[55:52] = i == 0 ? 4'h0 : a[55:52];
            b = $urandom;
            m = 2'($urandom);
            n = $urandom % 16;
            w = '{{28'h0, i[0], m, 1'b1}, {28'h0, n[1:0], n[3:2]}, c[63:32], c[31:0], a[63:32], a[31:0], b};
            for (int j = 1; j < 8; j++) i_host.xfer(1, 8'(4 * (j % 7)), w[j % 7], q);
            k = 0;
            do begin @(negedge hclk); k++; end while (tv !== 1'b1 && k < 20);
            if (k >= 20) begin n_fail++; close_out(); end
            `CHK("texel", model(c, a, b, m, n), {tr, tg, tb, ta})
            @(posedge hclk);
            i_host.xfer(0, RESULT_OFS, 32'h0, q);
            `CHK("result", model(c, a, b, m, n), q)
        end
        i_host.xfer(0, 8'h40, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        close_out();
    end
endmodule
`default_nettype wire
